/* File: shared/aorf_pkg.sv */
// aorf_pkg: constants, field layouts and carrier types for the output/reset
// control word and the fault-flag word of the quad converter register bank.
// assumes: 16-bit register words, address in the top nibble of every word.
package aorf_pkg;

  localparam int WORD_W = 16;
  localparam int CHAN_W = 16;

  // field positions
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 12;
  localparam int MODE_MSB = 9;
  localparam int MODE_LSB = 8;
  localparam int RSTF_MSB = 7;
  localparam int RSTF_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;

  // register addresses; ADDR_READ_REQ is the read-request pseudo address
  localparam logic [3:0] ADDR_READ_REQ = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_FAULT = 4'h3;

  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] RSTF_RESET = 8'h00;
  localparam logic [9:0] FAULT_RESET = 10'h000;

  // reset-field codes
  localparam logic [7:0] CODE_SOFT = 8'h3C;
  localparam logic [7:0] CODE_HARD = 8'hFF;

  // output lane modes
  localparam logic [1:0] MODE_TWO = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_FOUR = 2'h2;
  localparam logic [1:0] MODE_ONE_ALT = 2'h3;

  // fault-flag bit positions; limit flags: channel n over = 2n+1, under = 2n
  localparam int FB_CHECK = 9;
  localparam int FB_SETUP = 8;
  localparam int FB_D_OVER = 7;
  localparam int FB_A_UNDER = 0;

  // frame lengths and the write-check code
  localparam logic [4:0] PLAIN_BITS = 5'h10;
  localparam logic [4:0] CHECKED_BITS = 5'h18;
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_INIT = 8'h00;

  // conversion results of one sample, channel a in the low word
  typedef struct packed {
    logic [CHAN_W-1:0] d;
    logic [CHAN_W-1:0] c;
    logic [CHAN_W-1:0] b;
    logic [CHAN_W-1:0] a;
  } aorf_conv_t;

  typedef struct packed {
    logic [CHAN_W-1:0] high;
    logic [CHAN_W-1:0] low;
  } aorf_thr_t;

  // last received serial frame
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [7:0] check;
    logic [4:0] bits;
  } aorf_frame_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } aorf_lanes_t;

endpackage : aorf_pkg

/* File: verilog/aorf_link_rx.sv */
// aorf_link_rx: serial word receiver running on the link clock.
// assumes: host shifts msb first, device samples on rising sclk while cs_n low;
// the frame stays stable after cs_n rises until the next frame starts.
`timescale 1ns/1ps
`default_nettype none
module aorf_link_rx
  import aorf_pkg::*;
(
  input wire logic i_sclk,          // link clock
  input wire logic i_cs_n,          // frame select, low active
  input wire logic i_reset_n,       // power-on reset
  input wire logic i_sdi,           // serial data in
  output aorf_frame_t o_frame       // last frame, stable between frames
);

  logic [4:0] cnt;
  logic [4:0] bits;
  logic [23:0] shreg;
  logic [4:0] next_cnt;

  // saturating count so over-long frames never wrap into a legal length
  assign next_cnt = (cnt == 5'h1F) ? cnt : cnt + 5'h01;

  // count restarts with each frame; cs_n high ends it without any sclk edge
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  // shifter and bit total survive cs_n so the core clock can read them later
  always_ff @(posedge i_sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shreg <= 24'h000000;
      bits <= 5'h00;
    end else begin
      shreg <= {shreg[22:0], i_sdi};
      bits <= next_cnt;
    end
  end

  assign o_frame.word = (bits == CHECKED_BITS) ? shreg[23:8] : shreg[15:0];
  assign o_frame.check = shreg[7:0];
  assign o_frame.bits = bits;

endmodule : aorf_link_rx
`default_nettype wire

/* File: verilog/aorf_lane_tx.sv */
// aorf_lane_tx: drives conversion results or a read reply onto the output lanes.
// assumes: mode, reply and results are held steady by the core clock during a
// frame; bits launch on falling sclk, the host samples on rising sclk.
`timescale 1ns/1ps
`default_nettype none
module aorf_lane_tx
  import aorf_pkg::*;
#(
  parameter int LANE_BITS = 64      // longest lane payload, four results
) (
  input wire logic i_sclk,          // link clock
  input wire logic i_cs_n,          // frame select, low active
  input wire logic [1:0] i_mode,    // output lane mode
  input wire logic i_reply_pending, // send the read reply in this frame
  input wire logic [WORD_W-1:0] i_reply_word, // read reply word
  input wire aorf_conv_t i_conv,    // result snapshot
  input wire logic i_alert_sel,     // lane d pin shows the flag
  input wire logic i_alert_level,   // any limit flag set
  output aorf_lanes_t o_lane,       // lane data
  output aorf_lanes_t o_lane_oe     // lane output enables
);

  // the bit pointer below is six bits wide, so only four full results fit
  if (LANE_BITS != 4 * CHAN_W) begin : g_bad_lane_bits
    $error("LANE_BITS must hold four results");
  end

  localparam logic [47:0] PAD48 = 48'h000000000000;
  localparam logic [31:0] PAD32 = 32'h00000000;

  logic [5:0] cnt;
  logic [LANE_BITS-1:0] src_a, src_b, src_c, src_d;
  logic flag_on_d;
  aorf_lanes_t next_lane;

  // lane payloads per mode; a read reply always goes out on lane a alone
  always_comb begin
    src_a = {i_conv.a, PAD48};
    src_b = {LANE_BITS{1'b0}};
    src_c = {LANE_BITS{1'b0}};
    src_d = {LANE_BITS{1'b0}};
    if (i_reply_pending) begin
      src_a = {i_reply_word, PAD48};
    end else begin
      unique case (i_mode)
        MODE_TWO: begin
          src_a = {i_conv.a, i_conv.b, PAD32};
          src_b = {i_conv.c, i_conv.d, PAD32};
        end
        MODE_FOUR: begin
          src_a = {i_conv.a, PAD48};
          src_b = {i_conv.b, PAD48};
          src_c = {i_conv.c, PAD48};
          src_d = {i_conv.d, PAD48};
        end
        MODE_ONE, MODE_ONE_ALT: begin
          src_a = {i_conv.a, i_conv.b, i_conv.c, i_conv.d};
        end
      endcase
    end
  end

  // the flag pin choice only counts in mode one
  assign flag_on_d = i_alert_sel && (i_mode == MODE_ONE);

  assign next_lane.a = src_a[6'h3F - cnt];
  assign next_lane.b = src_b[6'h3F - cnt];
  assign next_lane.c = src_c[6'h3F - cnt];
  assign next_lane.d = flag_on_d ? i_alert_level : src_d[6'h3F - cnt];

  // launch counter and lane flops, cleared by the frame's own select
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt <= 6'h00;
      o_lane <= '0;
    end else begin
      cnt <= cnt + 6'h01;
      o_lane <= next_lane;
    end
  end

  // lanes float outside frames; the flag pin is driven whenever selected in mode one
  assign o_lane_oe.a = !i_cs_n;
  assign o_lane_oe.b = !i_cs_n && !i_reply_pending && (i_mode == MODE_TWO || i_mode == MODE_FOUR);
  assign o_lane_oe.c = !i_cs_n && !i_reply_pending && (i_mode == MODE_FOUR);
  assign o_lane_oe.d = flag_on_d || (!i_cs_n && !i_reply_pending && (i_mode == MODE_FOUR));

endmodule : aorf_lane_tx
`default_nettype wire

/* File: verilog/aorf_regs.sv */
// aorf_regs: output/reset control word and sticky fault-flag word, with the
// serial register port and the result lanes attached.
// assumes: i_mclk core clock, i_sclk link clock from the host; host leaves at
// least 6 core cycles between frames and 4 after cs_n falls before sclk.
//
// What this block does
// - address rides in top nibble of words
// - mode 00 drives lanes a and b
// - mode 01 or 11 uses lane a only
// - mode 10 spreads over all four lanes
// - code 3C soft reset clears fault flags except setup
// - code FF hard reset restores all defaults
// - any other code does nothing
// - control word resets to zero, reserved read zero
// - bad check code sets sticky flag nine
// - setup failure flag cleared only by hard reset
// - over-limit flags for d, c, b sticky
// - under-limit flags for d, c sticky
// - fault word read-only, resets zero, reserved zero
// - channel a flags, b under, behave alike
// - under flag only when result below threshold
// - flag pin choice honoured in mode 01 only
`timescale 1ns/1ps
`default_nettype none
module aorf_regs
  import aorf_pkg::*;
(
  input wire logic i_mclk,            // core clock, 10 MHz
  input wire logic i_reset_n,         // asynchronous reset, low active
  input wire logic i_sclk,            // link clock from host
  input wire logic i_cs_n,            // frame select, low active
  input wire logic i_sdi,             // serial data from host
  input wire aorf_conv_t i_conv,      // new conversion results
  input wire logic i_conv_valid,      // results valid, one-cycle pulse
  input wire aorf_thr_t i_thr,        // limit thresholds
  input wire logic i_setup_fail,      // startup load failed, pulse
  input wire logic i_alert_pin_sel,   // lane d pin shows the flag
  output aorf_lanes_t o_lane,         // output lanes
  output aorf_lanes_t o_lane_oe,      // output lane enables
  output logic [1:0] o_lane_mode,     // current lane mode
  output logic o_soft_reset,          // flush pulse to datapath
  output logic o_hard_reset           // full reset pulse to datapath
);

  // computes the write-check code over one register word
  function automatic logic [7:0] check_code(input logic [WORD_W-1:0] w);
    logic [7:0] c;
    c = CHECK_INIT;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction : check_code

  // over/under hits for all four channels, channel a in the low pair
  function automatic logic [7:0] limit_hits(input aorf_conv_t cv, input aorf_thr_t th);
    logic [4*CHAN_W-1:0] v;
    logic [7:0] h;
    v = cv;
    h = 8'h00;
    for (int n = 0; n < 4; n++) begin
      h[2*n+1] = v[n*CHAN_W +: CHAN_W] > th.high;
      h[2*n] = v[n*CHAN_W +: CHAN_W] < th.low;
    end
    return h;
  endfunction : limit_hits

  aorf_frame_t frame;
  logic cs_meta, cs_sync, cs_last;
  logic [1:0] mode;
  logic [7:0] rstf;
  logic [9:0] flags;
  logic [WORD_W-1:0] reply_word;
  logic reply_pending;
  aorf_conv_t conv_hold;

  aorf_link_rx u_rx (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_reset_n(i_reset_n),
    .i_sdi(i_sdi),
    .o_frame(frame)
  );

  // select crosses as a level through two flops; the third only finds the edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_last <= 1'b1;
    end else begin
      cs_meta <= i_cs_n;
      cs_sync <= cs_meta;
      cs_last <= cs_sync;
    end
  end

  // frame decode: the word is safe to read once the frame has ended
  logic frame_end, len_plain, len_checked, check_ok, frame_good, check_bad;
  logic [3:0] addr, sel;
  logic ctrl_write, read_req, read_fault;
  assign frame_end = cs_sync && !cs_last;
  assign len_plain = frame.bits == PLAIN_BITS;
  assign len_checked = frame.bits == CHECKED_BITS;
  assign check_ok = check_code(frame.word) == frame.check;
  assign frame_good = frame_end && (len_plain || (len_checked && check_ok));
  assign check_bad = frame_end && len_checked && !check_ok;
  assign addr = frame.word[ADDR_MSB:ADDR_LSB];
  assign sel = frame.word[SEL_MSB:SEL_LSB];
  assign ctrl_write = frame_good && (addr == ADDR_CTRL);
  assign read_req = frame_good && (addr == ADDR_READ_REQ);
  assign read_fault = read_req && (sel == ADDR_FAULT);

  // reset codes act from the stored field; other values do nothing
  logic soft_go, hard_go;
  assign soft_go = rstf == CODE_SOFT;
  assign hard_go = rstf == CODE_HARD;

  // control word; the field clears after acting so one write acts once
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode <= MODE_RESET;
      rstf <= RSTF_RESET;
    end else if (ctrl_write) begin
      mode <= frame.word[MODE_MSB:MODE_LSB];
      rstf <= frame.word[RSTF_MSB:RSTF_LSB];
    end else if (hard_go) begin
      mode <= MODE_RESET;
      rstf <= RSTF_RESET;
    end else if (soft_go) begin
      rstf <= RSTF_RESET;
    end
  end

  // sticky flags: clearing read, soft and hard reset (setup flag by hard reset only), with every set winning
  logic [9:0] set_mask, clr_mask, next_flags;
  assign set_mask[FB_CHECK] = check_bad;
  assign set_mask[FB_SETUP] = i_setup_fail;
  assign set_mask[FB_D_OVER:FB_A_UNDER] = i_conv_valid ? limit_hits(i_conv, i_thr) : 8'h00;
  assign clr_mask[FB_CHECK] = read_fault || soft_go || hard_go;
  assign clr_mask[FB_SETUP] = hard_go;
  assign clr_mask[FB_D_OVER:FB_A_UNDER] = {8{read_fault || soft_go || hard_go}};
  assign next_flags = (flags & ~clr_mask) | set_mask;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags <= FAULT_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // read replies carry the address nibble; reserved bits and unknown words read zero
  logic [WORD_W-1:0] next_reply;
  assign next_reply = (sel == ADDR_CTRL) ? {ADDR_CTRL, 2'h0, mode, rstf} :
                      (sel == ADDR_FAULT) ? {ADDR_FAULT, 2'h0, flags} :
                      {sel, 12'h000};

  // a reply is offered in the frame after the request, then withdrawn
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reply_word <= '0;
      reply_pending <= 1'b0;
    end else if (frame_end) begin
      reply_pending <= read_req;
      if (read_req) begin
        reply_word <= next_reply;
      end
    end
  end

  // snapshot only while idle so the lanes see steady data in a frame;
  // a result arriving mid-frame waits for the next conversion
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      conv_hold <= '0;
    end else if (hard_go || soft_go) begin
      conv_hold <= '0;
    end else if (i_conv_valid && cs_sync) begin
      conv_hold <= i_conv;
    end
  end

  // reset pulses to the datapath, one cycle each
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_soft_reset <= 1'b0;
      o_hard_reset <= 1'b0;
    end else begin
      o_soft_reset <= soft_go;
      o_hard_reset <= hard_go;
    end
  end

  assign o_lane_mode = mode;

  aorf_lane_tx #(
    .LANE_BITS(4 * CHAN_W)
  ) u_tx (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_mode(mode),
    .i_reply_pending(reply_pending),
    .i_reply_word(reply_word),
    .i_conv(conv_hold),
    .i_alert_sel(i_alert_pin_sel),
    .i_alert_level(|flags[FB_D_OVER:FB_A_UNDER]),
    .o_lane(o_lane),
    .o_lane_oe(o_lane_oe)
  );

  // checks, all on the core clock
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  property p_reply_addr;
    read_req && (sel == ADDR_CTRL) |=> reply_word[15:12] == ADDR_CTRL && reply_word[11:10] == 2'h0;
  endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply lacks control address");

  property p_reply_fault;
    read_req && (sel == ADDR_FAULT) |=> reply_word == {ADDR_FAULT, 2'h0, $past(flags)};
  endproperty
  a_reply_fault: assert property (p_reply_fault) else $error("fault reply wrong");

  property p_soft;
    soft_go && !ctrl_write && !i_setup_fail
      |=> o_soft_reset && rstf == 8'h00 && flags[FB_SETUP] == $past(flags[FB_SETUP]) && mode == $past(mode);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset misbehaved");

  property p_hard;
    hard_go && !ctrl_write |=> o_hard_reset && mode == MODE_RESET && (flags & ~$past(set_mask)) == 10'h000;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset incomplete");

  property p_other_code;
    !soft_go && !hard_go |=> !o_soft_reset && !o_hard_reset;
  endproperty
  a_other_code: assert property (p_other_code) else $error("reset pulse without code");

  property p_field_return;
    (soft_go || hard_go) && !ctrl_write |=> rstf == 8'h00 ##1 !o_soft_reset && !o_hard_reset;
  endproperty
  a_field_return: assert property (p_field_return) else $error("reset field not cleared");

  property p_check_flag;
    check_bad |=> flags[FB_CHECK] ##1 (flags[FB_CHECK] || $past(read_fault || soft_go || hard_go));
  endproperty
  a_check_flag: assert property (p_check_flag) else $error("write-check flag lost");

  property p_setup_keep;
    flags[FB_SETUP] && !hard_go |=> flags[FB_SETUP];
  endproperty
  a_setup_keep: assert property (p_setup_keep) else $error("setup flag cleared");

  property p_set_wins;
    read_fault && i_conv_valid && (i_conv.d > i_thr.high) |=> flags[FB_D_OVER];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clearing read");

  property p_under_a;
    i_conv_valid && (i_conv.a >= i_thr.low) && !flags[FB_A_UNDER] |=> !flags[FB_A_UNDER];
  endproperty
  a_under_a: assert property (p_under_a) else $error("under flag without cause");

  property p_read_clear;
    read_fault && !i_conv_valid && !check_bad |=> flags[FB_D_OVER:FB_A_UNDER] == 8'h00 && !flags[FB_CHECK];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  // a good write to the control word lands its mode bits
  property p_ctrl_write;
    ctrl_write |=> mode == $past(frame.word[MODE_MSB:MODE_LSB]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write did not land");

  // a write aimed at the fault word leaves every flag as it was
  property p_fault_ro;
    frame_good && (addr == ADDR_FAULT) && !i_conv_valid && !i_setup_fail && !soft_go && !hard_go
      |=> flags == $past(flags);
  endproperty
  a_fault_ro: assert property (p_fault_ro) else $error("fault word took a write");

  // a startup load failure always shows in the setup flag
  property p_setup_set;
    i_setup_fail |=> flags[FB_SETUP];
  endproperty
  a_setup_set: assert property (p_setup_set) else $error("setup failure not flagged");

  // channel d under-limit sits just below its over-limit bit
  property p_under_d;
    i_conv_valid && (i_conv.d < i_thr.low) |=> flags[FB_D_OVER - 1];
  endproperty
  a_under_d: assert property (p_under_d) else $error("channel d under flag missing");

  // outside frames nothing drives unless the flag pin is chosen in mode one
  property p_idle_float;
    i_cs_n && !(i_alert_pin_sel && (mode == MODE_ONE)) |-> o_lane_oe == 4'h0;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("lane driven outside frame");

  // in mode one with the flag chosen, the shared pin stays driven
  property p_flag_pin;
    i_cs_n && i_alert_pin_sel && (mode == MODE_ONE) |-> o_lane_oe.d;
  endproperty
  a_flag_pin: assert property (p_flag_pin) else $error("flag pin not driven");

endmodule : aorf_regs
`default_nettype wire

/* File: tb/aorf_host_model.sv */
// aorf_host_model: host controller on the serial register port of the bank.
// assumes: 32 ns link clock that stops between frames, msb first, lanes read on rising sclk.
`timescale 1ns/1ps
`default_nettype none
module aorf_host_model
  import aorf_pkg::*;
(
  input wire aorf_lanes_t i_lane,     // lane data from the device
  input wire aorf_lanes_t i_lane_oe,  // lane enables from the device
  output logic o_sclk,                // link clock, idles high
  output logic o_cs_n,                // frame select, low active
  output logic o_sdi                  // serial data to the device
);
  logic [15:0] rx_a;
  logic [15:0] rx_b;
  logic [15:0] rx_c;
  logic [15:0] rx_d;
  aorf_lanes_t oe_seen;

  // quiet bus at power-up; a short select pulse under reset clears the
  // device's link counters, which only a rising select can reset
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b0;
    o_sdi = 1'b0;
    #10ns;
    o_cs_n = 1'b1;
  end

  // check byte over the word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CHECK_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CHECK_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // one frame of n bits; flip spoils the check byte on purpose
  task automatic xfer(input logic [15:0] w, input logic [4:0] n, input logic [7:0] flip);
    logic [23:0] f;
    f = {w, crc8(w) ^ flip};
    o_cs_n = 1'b0;
    #400ns;
    for (int i = 0; i < n; i++) begin
      o_sclk = 1'b0;
      o_sdi = f[23-i];
      #16ns;
      o_sclk = 1'b1;
      if (i < 16) begin
        rx_a = {rx_a[14:0], i_lane.a};
        rx_b = {rx_b[14:0], i_lane.b};
        rx_c = {rx_c[14:0], i_lane.c};
        rx_d = {rx_d[14:0], i_lane.d};
      end
      oe_seen = i_lane_oe;
      #16ns;
    end
    // released line shows the inverse so a stale value cannot pass
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #800ns;
  endtask : xfer
endmodule : aorf_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the output/reset control and fault-flag words.
// assumes: the host model speaks the serial port; core inputs change on falling mclk.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aorf_pkg::*;
  logic i_mclk, i_reset_n, sclk, cs_n, sdi, i_conv_valid, i_setup_fail, i_alert_pin_sel;
  aorf_conv_t i_conv;
  aorf_thr_t i_thr;
  aorf_lanes_t lane, lane_oe;
  logic [1:0] lane_mode;
  logic soft_rst, hard_rst;
  logic [15:0] v;
  logic [1:0] md;
  logic [3:0] exp_oe;
  logic [7:0] odd_code [4];
  int n_mismatch, tests_run, n_soft, n_hard, cyc;

  aorf_regs aorf_regs_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .i_conv(i_conv), .i_conv_valid(i_conv_valid), .i_thr(i_thr),
    .i_setup_fail(i_setup_fail), .i_alert_pin_sel(i_alert_pin_sel), .o_lane(lane),
    .o_lane_oe(lane_oe), .o_lane_mode(lane_mode), .o_soft_reset(soft_rst), .o_hard_reset(hard_rst));
  aorf_host_model aorf_host_model_inst (.i_lane(lane), .i_lane_oe(lane_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_sdi(sdi));

  always #50ns i_mclk = ~i_mclk;

  // pulse widths are counted so a stuck pulse shows as a count above one;
  // sampled on the falling edge, clear of the edge that launches a pulse
  always @(negedge i_mclk) begin
    cyc++;
    if (soft_rst === 1'b1) n_soft++;
    if (hard_rst === 1'b1) n_hard++;
    if (cyc >= 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] w);
    aorf_host_model_inst.xfer(w, PLAIN_BITS, 8'h00);
  endtask : wr

  // read request, then the reply rides the following frame
  task automatic rd(input logic [3:0] a, output logic [15:0] r);
    wr({12'h000, a});
    wr(16'h1000);
    r = aorf_host_model_inst.rx_a;
  endtask : rd

  task automatic conv_pulse(input aorf_conv_t c, input logic fail);
    @(negedge i_mclk);
    i_conv = c;
    i_conv_valid = 1'b1;
    i_setup_fail = fail;
    @(negedge i_mclk);
    i_conv_valid = 1'b0;
    i_setup_fail = 1'b0;
  endtask : conv_pulse

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    i_mclk = 1'b0;
    i_reset_n = 1'b0;
    i_conv = '0;
    i_conv_valid = 1'b0;
    i_setup_fail = 1'b0;
    i_alert_pin_sel = 1'b0;
    i_thr = {16'h8000, 16'h1000};
    odd_code = '{8'h55, 8'h3D, 8'hFE, 8'h3B};
    repeat (2) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    rd(ADDR_CTRL, v); check(v, 16'h2000);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    rd(4'h7, v); check(v, 16'h7000);
    $display("test reset values done");
    // every lane mode, with the flag pin choice both ways
    for (int m = 0; m < 8; m++) begin
      md = m[1:0];
      @(negedge i_mclk);
      i_alert_pin_sel = m[2];
      wr({6'h08, md, 8'h00});
      check(lane_mode, md);
      rd(ADDR_CTRL, v); check(v, {6'h08, md, 8'h00});
      conv_pulse({16'h4D4D, 16'h3C3C, 16'h2B2B, 16'h1A1A}, 1'b0);
      wr(16'h1000);
      check(aorf_host_model_inst.rx_a, 16'h1A1A);
      exp_oe = (md == 2'h0) ? 4'hC : (md == 2'h2) ? 4'hF : {3'b100, m[2] & (md == 2'h1)};
      check(aorf_host_model_inst.oe_seen, exp_oe);
      if (md == 2'h0) check(aorf_host_model_inst.rx_b, 16'h3C3C);
      if (md == 2'h2) check(aorf_host_model_inst.rx_b, 16'h2B2B);
      if (md == 2'h2) check(aorf_host_model_inst.rx_c, 16'h3C3C);
      if (md == 2'h2) check(aorf_host_model_inst.rx_d, 16'h4D4D);
    end
    $display("test lane modes done");
    // sticky limit flags, then cleared by the read
    conv_pulse({16'hF000, 16'h0500, 16'h9000, 16'h0800}, 1'b0);
    rd(ADDR_FAULT, v); check(v, 16'h3099);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    conv_pulse({16'h0100, 16'hA000, 16'h0200, 16'h9999}, 1'b0);
    rd(ADDR_FAULT, v); check(v, 16'h3066);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    // a limit event in the very cycle of the clearing read survives it;
    // the frame starts on a falling edge so the read acts three edges after select rises
    @(negedge i_mclk);
    fork
      wr({12'h000, ADDR_FAULT});
      begin
        @(posedge cs_n);
        repeat (2) @(posedge i_mclk);
        conv_pulse({16'hF000, 16'h2000, 16'h2000, 16'h2000}, 1'b0);
      end
    join
    wr(16'h1000);
    check(aorf_host_model_inst.rx_a, 16'h3000);
    rd(ADDR_FAULT, v); check(v, 16'h3080);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    $display("test limit flags done");
    // checked writes, good then spoilt
    aorf_host_model_inst.xfer(16'h2100, CHECKED_BITS, 8'h00);
    check(lane_mode, 2'h1);
    aorf_host_model_inst.xfer(16'h2200, CHECKED_BITS, 8'h01);
    check(lane_mode, 2'h1);
    rd(ADDR_FAULT, v); check(v, 16'h3200);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    wr(16'h33FF);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    $display("test write check done");
    // soft reset keeps the setup flag and the mode
    conv_pulse({16'hF000, 16'h0500, 16'h9000, 16'h0800}, 1'b1);
    wr(16'h213C);
    check(aorf_host_model_inst.rx_d, 16'hFFFF);
    check(16'(n_soft), 16'h0001);
    check(lane_mode, 2'h1);
    rd(ADDR_CTRL, v); check(v, 16'h2100);
    rd(ADDR_FAULT, v); check(v, 16'h3100);
    rd(ADDR_FAULT, v); check(v, 16'h3100);
    $display("test soft reset done");
    // codes that are neither reset stay in the field and do nothing
    foreach (odd_code[i]) begin
      wr({8'h21, odd_code[i]});
      rd(ADDR_CTRL, v); check(v, {8'h21, odd_code[i]});
    end
    check(16'(n_soft), 16'h0001);
    check(16'(n_hard), 16'h0000);
    $display("test other codes done");
    // hard reset restores defaults, setup flag included
    wr(16'h22FF);
    check(16'(n_hard), 16'h0001);
    check(lane_mode, 2'h0);
    rd(ADDR_CTRL, v); check(v, 16'h2000);
    rd(ADDR_FAULT, v); check(v, 16'h3000);
    $display("test hard reset done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
